// ===== shared/adcc_pkg.sv
// constants and carriers for the single-conversion converter control block
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register slave
package adcc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_MHZ   = 100;
  localparam int unsigned SAMPLE_TIME_NS = 500; // sample-and-hold window
  localparam int unsigned SETTLE_TIME_NS = 40;  // trial dac settle per bit
  // least times round up to whole cycles
  localparam int unsigned SAMPLE_CYCLES =
    (SAMPLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] SAMPLE_LOAD = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES - 1);
  // ---------------------------------------------------------------
  // resolution and result layout
  // ---------------------------------------------------------------
  localparam int unsigned RES_W      = 10;
  localparam int unsigned RES8_BITS  = 8;
  localparam int unsigned RESULT_W   = 16;
  localparam int unsigned RESULT_PAD = RESULT_W - RES_W; // six zero bits
  localparam logic [3:0]  BIT_MSB    = 4'(RES_W - 1);
  localparam logic [3:0]  BIT_LSB10  = 4'h0;
  localparam logic [3:0]  BIT_LSB8   = 4'(RES_W - RES8_BITS);
  localparam int unsigned CONV10_CYCLES = SAMPLE_CYCLES + RES_W * SETTLE_CYCLES;
  localparam int unsigned CONV8_CYCLES  = SAMPLE_CYCLES + RES8_BITS * SETTLE_CYCLES;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  OFS_MODE0  = 4'h0;
  localparam logic [3:0]  OFS_RESULT = 4'h4;
  localparam logic [3:0]  OFS_STATUS = 4'h8;
  localparam int unsigned CHAN_W     = 3;
  localparam int unsigned MODE_START_BIT = 0;
  localparam int unsigned MODE_RES_BIT   = 1;
  localparam int unsigned MODE_CHAN_LSB  = 2;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              res8;
    logic              start;
  } adcc_mode_t;
  localparam adcc_mode_t MODE_RESET = '{chan: CHAN_RESET, res8: 1'b0, start: 1'b0};
  typedef struct packed {
    logic             busy;
    logic             done;
    logic [RES_W-1:0] code;
  } adcc_sar_stat_t;
endpackage

// ===== hw/adcc_sync.sv
// two-stage synchroniser for one level coming from outside the clock domain
// assumes the input is a slowly changing level such as a comparator output
`timescale 1ns/1ps
module adcc_sync (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic din_i,
  output logic      dout_o
);
  logic meta;
  logic sync;
  logic next_meta;
  logic next_sync;

  // first stage feeds only the second stage
  always_comb begin
    next_meta = din_i;
    next_sync = meta;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
    end
  end

  assign dout_o = sync;
endmodule

// ===== hw/adcc_sar.sv
// successive-approximation sequencer: sample window, then one trial per bit
// assumes cmp_i is synchronised and high when the held input exceeds trial_o
`timescale 1ns/1ps
module adcc_sar
  import adcc_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       go_i,
  input  wire logic       abort_i,
  input  wire logic       res8_i,
  input  wire logic       cmp_i,
  output logic [RES_W-1:0] trial_o,
  output logic            sample_o,
  output adcc_sar_stat_t  stat_o
);
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL} adcc_sar_state_t;

  adcc_sar_state_t  state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [3:0]       bit_idx, next_bit_idx;
  logic [RES_W-1:0] code, next_code;
  logic             sample, next_sample;
  logic             done, next_done;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // settle count must cover the two synchroniser stages on cmp_i
  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_bit_idx = bit_idx;
    next_code    = code;
    next_sample  = sample;
    next_done    = 1'b0;
    case (state)
      SAR_IDLE: begin
        if (go_i) begin
          next_state  = SAR_SAMPLE;
          next_cnt    = SAMPLE_LOAD;
          next_sample = 1'b1;
          next_code   = '0;
        end
      end
      SAR_SAMPLE: begin
        if (cnt == '0) begin
          next_sample        = 1'b0;
          next_state         = SAR_TRIAL;
          next_bit_idx       = BIT_MSB;
          next_code[BIT_MSB] = 1'b1;
          next_cnt           = SETTLE_LOAD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      SAR_TRIAL: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          if (!cmp_i) begin
            next_code[bit_idx] = 1'b0; // trial too high, drop the bit
          end
          // 8-bit mode stops two bits early, low bits stay zero
          if (bit_idx == (res8_i ? BIT_LSB8 : BIT_LSB10)) begin
            next_state = SAR_IDLE;
            next_done  = 1'b1;
          end else begin
            next_bit_idx               = bit_idx - 4'h1;
            next_code[bit_idx - 4'h1]  = 1'b1;
            next_cnt                   = SETTLE_LOAD;
          end
        end
      end
      default: begin
        next_state = SAR_IDLE;
      end
    endcase
    if (abort_i) begin
      next_state  = SAR_IDLE;
      next_sample = 1'b0;
      next_done   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state   <= SAR_IDLE;
      cnt     <= '0;
      bit_idx <= 4'h0;
      code    <= '0;
      sample  <= 1'b0;
      done    <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      bit_idx <= next_bit_idx;
      code    <= next_code;
      sample  <= next_sample;
      done    <= next_done;
    end
  end

  assign trial_o     = code;
  assign sample_o    = sample;
  assign stat_o.busy = (state != SAR_IDLE);
  assign stat_o.done = done;
  assign stat_o.code = code;
endmodule

// ===== hw/adcc_top.sv
// single-conversion converter control with an Avalon-MM register slave
// assumes an analog front end: channel mux, sample-hold, trial dac, comparator
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              cmp_i,
  output logic [CHAN_W-1:0]      chan_sel_o,
  output logic                   sample_o,
  output logic [RES_W-1:0]       trial_o,
  output logic                   conv_end_irq_o
);
  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  // a register is hit by any write at its offset with byte lane 0 on
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs,
                               input logic [3:0]        be);
    hit = (a == ofs) && be[0];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  adcc_mode_t            mode, next_mode;
  logic [RESULT_W-1:0]   result, next_result;
  logic                  done_flag, next_done_flag;
  logic                  irq, next_irq;
  logic [CHAN_W-1:0]     chan_sel, next_chan_sel;
  logic                  wait_q, next_wait;
  logic [31:0]           rdata, next_rdata;
  logic                  cmp_sync;
  logic                  go;
  logic                  abort;
  logic                  acc;
  logic                  wr_mode;
  logic                  wr_stat;
  logic                  set_start;
  adcc_sar_stat_t        sar_stat;
  logic [RES_W-1:0]      sar_trial;
  logic                  sar_sample;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // waitrequest idles high and drops for one cycle per request;
  // the access completes at the edge that sees it low
  always_comb begin
    next_wait  = !((avs_read_i || avs_write_i) && wait_q);
    next_rdata = 32'h0000_0000;
    if (avs_read_i && wait_q) begin
      case (avs_address_i)
        OFS_MODE0:  next_rdata = {27'h0, mode};
        OFS_RESULT: next_rdata = {16'h0, result};
        OFS_STATUS: next_rdata = {30'h0, done_flag, sar_stat.busy};
        default:    next_rdata = 32'h0000_0000; // unmapped reads zero
      endcase
    end else if (!wait_q) begin
      next_rdata = rdata; // hold through the completing edge
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
      rdata  <= 32'h0000_0000;
    end else begin
      wait_q <= next_wait;
      rdata  <= next_rdata;
    end
  end

  // write strobes for this completing edge
  assign acc       = avs_write_i && !wait_q;
  assign wr_mode   = acc && hit(avs_address_i, OFS_MODE0, avs_byteenable_i);
  assign wr_stat   = acc && hit(avs_address_i, OFS_STATUS, avs_byteenable_i);
  assign set_start = wr_mode && avs_writedata_i[MODE_START_BIT];

  // ---------------------------------------------------------------
  // conversion control
  // ---------------------------------------------------------------
  // launch once per start; done blocks relaunch before the clear lands
  assign go    = mode.start && !sar_stat.busy && !sar_stat.done;
  // a write of 0 to the start bit stops a running conversion
  assign abort = wr_mode && !avs_writedata_i[MODE_START_BIT] && mode.start;

  // mode register, result register, sticky done and interrupt pulse
  always_comb begin
    next_mode      = mode;
    next_result    = result;
    next_done_flag = done_flag;
    next_irq       = 1'b0;
    next_chan_sel  = chan_sel;
    if (sar_stat.done) begin
      next_result     = {sar_stat.code, {RESULT_PAD{1'b0}}};
      next_irq        = 1'b1;
      next_mode.start = 1'b0;
      next_done_flag  = 1'b1;
    end
    if (wr_stat && avs_writedata_i[STAT_DONE_BIT] && !sar_stat.done) begin
      next_done_flag = 1'b0; // write one clears, a new end wins
    end
    if (wr_mode) begin
      // channel and resolution are frozen while a conversion runs
      if (!mode.start) begin
        next_mode.chan = avs_writedata_i[MODE_CHAN_LSB +: CHAN_W];
        next_mode.res8 = avs_writedata_i[MODE_RES_BIT];
      end
      if (set_start) begin
        next_mode.start = 1'b1; // set wins over completion
      end else begin
        next_mode.start = 1'b0;
      end
    end
    if (go) begin
      next_chan_sel = mode.chan; // mux held for the whole conversion
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode      <= MODE_RESET;
      result    <= RESULT_RESET;
      done_flag <= 1'b0;
      irq       <= 1'b0;
      chan_sel  <= CHAN_RESET;
    end else begin
      mode      <= next_mode;
      result    <= next_result;
      done_flag <= next_done_flag;
      irq       <= next_irq;
      chan_sel  <= next_chan_sel;
    end
  end

  // ---------------------------------------------------------------
  // converter core
  // ---------------------------------------------------------------
  // comparator comes from the analog side, so it is synchronised first
  adcc_sync u_cmp_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .din_i     (cmp_i),
    .dout_o    (cmp_sync)
  );

  adcc_sar u_sar (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .go_i      (go),
    .abort_i   (abort),
    .res8_i    (mode.res8),
    .cmp_i     (cmp_sync),
    .trial_o   (sar_trial),
    .sample_o  (sar_sample),
    .stat_o    (sar_stat)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o    = rdata;
  assign avs_waitrequest_o = wait_q;
  assign chan_sel_o        = chan_sel;
  assign sample_o          = sar_sample;
  assign trial_o           = sar_trial;
  assign conv_end_irq_o    = irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // busy cycles of the current conversion, cleared on each launch
  logic [15:0] conv_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || go) begin
      conv_cnt <= 16'h0000;
    end else if (sar_stat.busy) begin
      conv_cnt <= conv_cnt + 16'h0001;
    end
  end

  sequence s_start_write;
    set_start && !mode.start && !sar_stat.busy && !sar_stat.done;
  endsequence

  sequence s_sample_open;
    sample_o ##1 sample_o;
  endsequence

  sequence s_conv_end;
    sar_stat.done ##1 conv_end_irq_o;
  endsequence

  a_start_launch: assert property (
    s_start_write |-> ##[1:3] s_sample_open
  ) else $error("start write did not open a sample window");

  a_end_result: assert property (
    s_conv_end |-> result == {$past(sar_stat.code), {RESULT_PAD{1'b0}}}
  ) else $error("result not loaded with the conversion end");

  a_irq_pulse: assert property (
    conv_end_irq_o |=> !conv_end_irq_o
  ) else $error("end interrupt longer than one cycle");

  a_start_self_clear: assert property (
    sar_stat.done && !set_start |=> !mode.start ##1 !sar_stat.busy
  ) else $error("start bit not cleared at conversion end");

  a_res_ten_len: assert property (
    conv_end_irq_o && !mode.res8 |-> conv_cnt == 16'(CONV10_CYCLES)
  ) else $error("10-bit conversion took the wrong number of cycles");

  a_res_eight_len: assert property (
    conv_end_irq_o && mode.res8 |-> conv_cnt == 16'(CONV8_CYCLES) && result[7:6] == 2'b00
  ) else $error("8-bit conversion length or low bits wrong");

  a_result_low_zero: assert property (
    result[RESULT_PAD-1:0] == '0
  ) else $error("result low bits not zero");

  a_result_change: assert property (
    !$stable(result) |-> conv_end_irq_o
  ) else $error("result changed without a conversion end");

  a_bus_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o
  ) else $error("bus request not answered in one cycle");

  a_wait_idle: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o
  ) else $error("waitrequest low without a request");

  a_stat_clear: assert property (
    wr_stat && avs_writedata_i[STAT_DONE_BIT] && !sar_stat.done |=> !done_flag
  ) else $error("done flag not cleared by a write of one");

  // ---------------------------------------------------------------
  // checks: conversion end
  // ---------------------------------------------------------------
  // pulse, sticky flag and result must all trace back to one sequencer
  // done; a stray pulse would wake software to a stale result
  a_irq_from_done: assert property (
    sar_stat.done |=> conv_end_irq_o
  ) else $error("conversion end without an end pulse");

  a_irq_after_done: assert property (
    conv_end_irq_o |-> $past(sar_stat.done)
  ) else $error("end pulse without a conversion end");

  a_done_flag_set: assert property (
    sar_stat.done |=> done_flag
  ) else $error("done flag not set at conversion end");

  // ---------------------------------------------------------------
  // checks: launch, sequencing and abort
  // ---------------------------------------------------------------
  // the sample window and the first trial are timed from the launch,
  // so a slip here shows up as a wrong code long before the end pulse
  a_launch_chan: assert property (
    go && !abort |=> sample_o && chan_sel_o == $past(mode.chan)
  ) else $error("launch did not open sampling on the chosen channel");

  a_sample_len: assert property (
    $fell(sample_o) && sar_stat.busy |-> conv_cnt == 16'(SAMPLE_CYCLES)
  ) else $error("sample window of the wrong length");

  a_trial_first: assert property (
    $fell(sample_o) && sar_stat.busy |-> trial_o == {1'b1, {(RES_W-1){1'b0}}}
  ) else $error("first trial is not the top bit alone");

  a_busy_bounded: assert property (
    sar_stat.busy |-> conv_cnt < 16'(CONV10_CYCLES)
  ) else $error("conversion ran past its full length");

  a_start_held: assert property (
    mode.start && !sar_stat.done && !wr_mode |=> mode.start
  ) else $error("start bit dropped before the conversion end");

  a_fields_frozen: assert property (
    wr_mode && mode.start |=> mode.chan == $past(mode.chan) && mode.res8 == $past(mode.res8)
  ) else $error("channel or resolution changed while converting");

  a_abort_quiet: assert property (
    abort |=> !sar_stat.busy && !sample_o && !sar_stat.done
  ) else $error("abort left the sequencer running");
endmodule

// ===== sim/adcc_tb_top.sv
// self-checking bench for the single-conversion converter control block
// assumes adcc_pkg and adcc_top compiled first; bench models the comparator
`timescale 1ns/1ps
module adcc_tb_top
  import adcc_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus signals and counters
  // ---------------------------------------------------------------
  logic              sys_clk;
  logic              reset_i;
  logic [ADDR_W-1:0] avs_address_i;
  logic              avs_read_i;
  logic              avs_write_i;
  logic [31:0]       avs_writedata_i;
  logic [3:0]        avs_byteenable_i;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              cmp_i;
  logic [CHAN_W-1:0] chan_sel_o;
  logic              sample_o;
  logic [RES_W-1:0]  trial_o;
  logic              conv_end_irq_o;
  logic [RES_W-1:0]  ain;
  int                errors;
  int                checks_done;

  adcc_top dut (
    .sys_clk_i         (sys_clk),
    .reset_i           (reset_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .cmp_i             (cmp_i),
    .chan_sel_o        (chan_sel_o),
    .sample_o          (sample_o),
    .trial_o           (trial_o),
    .conv_end_irq_o    (conv_end_irq_o)
  );

  // analog input sits half an lsb above ain so the code settles on ain exactly
  assign cmp_i = ({ain, 1'b1} > {trial_o, 1'b0});

  // free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // holds the request until waitrequest is sampled low, then releases it
  task automatic bus_xfer(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                          input logic [3:0] be, output logic [31:0] rdata);
    int n;
    n = 0;
    // let an edge pass so a release and the next raise never share a step
    @(posedge sys_clk);
    avs_address_i    <= addr;
    avs_writedata_i  <= wdata;
    avs_byteenable_i <= be;
    avs_write_i      <= wr;
    avs_read_i       <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) errors++;
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] d, input logic [3:0] be = 4'hf);
    logic [31:0] dummy;
    bus_xfer(1'b1, addr, d, be, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    bus_xfer(1'b0, addr, 32'h0000_0000, 4'hf, d);
    check(what, d, exp);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset values, unmapped place and refused writes
  task automatic t_regs();
    rd_chk("mode0 reset", OFS_MODE0, 32'h0000_0000);
    rd_chk("result reset", OFS_RESULT, 32'h0000_0000);
    rd_chk("status reset", OFS_STATUS, 32'h0000_0000);
    wr(4'hc, 32'hffff_ffff);
    rd_chk("unmapped read", 4'hc, 32'h0000_0000);
    wr(OFS_MODE0, 32'h0000_0014, 4'he);
    rd_chk("mode0 no byte0", OFS_MODE0, 32'h0000_0000);
    wr(OFS_MODE0, 32'h0000_0016);
    rd_chk("mode0 fields", OFS_MODE0, 32'h0000_0016);
  endtask

  // one full conversion; judges launch, sample window, end pulse and result
  task automatic t_conv(input logic res8, input logic [2:0] ch, input logic [9:0] val);
    int          n;
    int          samp;
    logic [15:0] exp_res;
    logic [31:0] got;
    n    = 0;
    samp = 0;
    ain  <= val;
    exp_res = res8 ? {val[9:2], 8'h00} : {val, 6'h00};
    wr(OFS_MODE0, {27'h0, ch, res8, 1'b1});
    do begin
      @(posedge sys_clk);
      n++;
      if (sample_o === 1'b1) samp++;
    end while (conv_end_irq_o !== 1'b1 && n < 300);
    check("end pulse seen", conv_end_irq_o, 1'b1);
    check("sample cycles", samp, SAMPLE_CYCLES);
    check("channel select", chan_sel_o, ch);
    @(posedge sys_clk);
    check("end pulse width", conv_end_irq_o, 1'b0);
    bus_xfer(1'b0, OFS_RESULT, 32'h0000_0000, 4'hf, got);
    check("result value", got, {16'h0, exp_res});
    check("result shifted", got >> 6, res8 ? {22'h0, val[9:2], 2'b00} : {22'h0, val});
    rd_chk("start cleared", OFS_MODE0, {27'h0, ch, res8, 1'b0});
    rd_chk("done flag", OFS_STATUS, 32'h0000_0002);
    wr(OFS_STATUS, 32'h0000_0002);
    rd_chk("done cleared", OFS_STATUS, 32'h0000_0000);
  endtask

  // abort mid-conversion; field writes while running must not land
  task automatic t_abort();
    int n;
    n = 0;
    ain <= 10'h2aa;
    wr(OFS_MODE0, 32'h0000_0009);
    wr(OFS_MODE0, 32'h0000_001d);
    rd_chk("fields locked", OFS_MODE0, 32'h0000_0009);
    rd_chk("busy while run", OFS_STATUS, 32'h0000_0001);
    wr(OFS_MODE0, 32'h0000_0008);
    repeat (150) begin
      @(posedge sys_clk);
      if (conv_end_irq_o === 1'b1) n++;
    end
    check("abort no pulse", n, 0);
    rd_chk("abort result kept", OFS_RESULT, 32'h0000_ffc0);
    rd_chk("abort idle", OFS_STATUS, 32'h0000_0000);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    errors           = 0;
    checks_done      = 0;
    reset_i          = 1'b1;
    avs_address_i    = 4'h0;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    ain              = 10'h000;
    repeat (6) @(posedge sys_clk);
    reset_i <= 1'b0;
    @(posedge sys_clk);
    check("waitrequest idle", avs_waitrequest_o, 1'b1);
    t_regs();
    t_conv(1'b0, 3'h2, 10'h2c5);
    t_conv(1'b0, 3'h2, 10'h001);
    t_conv(1'b1, 3'h5, 10'h13b);
    t_conv(1'b0, 3'h7, 10'h3ff);
    t_abort();
    end_of_test();
  end

  // cuts a hang short well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
endmodule
